// >>> core/pm_status_pkg.sv
// Purpose : Shared constants for the power-management status and running counter block
// Assumes : Registers are word aligned; byte address is four times the register index
// Notes   : Register data sits in bits 7:0 of the 32-bit bus word
package pm_status_pkg;

   // ------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [13:0] idx_value_high    = 14'h1808;
   localparam logic [13:0] idx_value_low     = 14'h1809;
   localparam logic [13:0] idx_page_control  = 14'h180b;
   localparam logic [13:0] idx_warning_ctrl  = 14'h180c;
   localparam logic [13:0] idx_irq_status    = 14'h1810;
   localparam logic [13:0] idx_irq_mask      = 14'h1811;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int unsigned warning_flag_bit        = 7;
   localparam int unsigned warning_acknowledge_bit = 6;
   localparam int unsigned detect_level_bit        = 5;
   localparam int unsigned warning_level_bit       = 4;
   localparam int unsigned counter_clear_bit       = 7;
   localparam int unsigned counter_run_bit         = 5;
   localparam int unsigned counter_page_bit        = 0;
   localparam int unsigned irq_warning_bit         = 0;
   localparam int unsigned irq_wrap_bit            = 1;

   // ------------------------------------------------------------
   // Widths and reset values
   // ------------------------------------------------------------
   localparam int unsigned counter_width   = 16;
   localparam int unsigned irq_width       = 2;
   localparam logic [15:0] counter_reset   = 16'h0000;
   localparam logic [15:0] counter_one     = 16'h0001;
   localparam logic [7:0]  byte_reset      = 8'h00;
   localparam logic [1:0]  irq_reset       = 2'h0;

endpackage

// >>> core/pm_status_free_run_counter.sv
// Purpose : Low-voltage warning flag with trip selects, and a 16-bit running counter behind a page bit
// Assumes : All inputs synchronous to clock; slow_oscillator is the 1 kHz clock sampled as data
// Notes   : Trip selects survive resetn and clear only on power_on_resetn
//
// Notes on behaviour
// - Warning flag sets while supply is below the selected warning trip, also after reset.
// - Warning flag is sticky: one means warning now or since last clear.
// - Acknowledge write of one clears flag only without present warning; reads zero.
// - Detect select: zero picks low detect trip, one picks high trip.
// - Warning select: zero picks low warning trip, one picks high trip.
// - Low four bits of the warning control register read zero.
// - Enabled counter increments and wraps in run and all sleep modes unless halted.
// - Counter advances on both edges of the slow oscillator.
// - Clear write of one zeroes count; count may be seen from one.
// - Run bit zero freezes count, one lets it count.
// - Page bit one enables clear/run and shows count at the two shared addresses.
// - Page bit zero restores shared addresses; counter keeps its last control.
// - High byte at lower address, low byte at next; both reset zero.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module pm_status_free_run_counter
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        power_on_resetn,
   input  wire logic [15:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        supply_below_low_trip,
   input  wire logic        supply_below_high_trip,
   input  wire logic        slow_oscillator,
   output logic             detect_level_select,
   output logic             warning_level_select,
   output logic             irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] count;
      logic        run;
      logic        page;
      logic        osc_prev;
      logic        flag;
      logic [1:0]  irq_status;
      logic [1:0]  irq_mask;
      logic [7:0]  rdata;
      logic        waitreq;
      logic        irq;
   } state_t;

   typedef struct packed {
      logic detect_sel;
      logic warn_sel;
   } retained_t;

   state_t    state_reg;
   state_t    state_next;
   retained_t keep_reg;
   retained_t keep_next;

   logic [13:0] index;
   logic        accept_wr;
   logic        below_warn;
   logic        osc_edge;
   logic        clear_req;
   logic        wrap;
   logic        ack_req;

   assign index      = avs_address[15:2];
   assign below_warn = keep_reg.warn_sel ? supply_below_high_trip : supply_below_low_trip;
   assign osc_edge   = slow_oscillator != state_reg.osc_prev;
   // Writes take effect only at the edge where waitrequest is seen low
   assign accept_wr  = avs_write && !state_reg.waitreq && avs_byteenable[0];
   assign ack_req    = accept_wr && index == pm_status_pkg::idx_warning_ctrl
                       && avs_writedata[pm_status_pkg::warning_acknowledge_bit];
   // Controls need the page already set; a write that sets the page does not also act
   assign clear_req  = accept_wr && index == pm_status_pkg::idx_page_control && state_reg.page
                       && avs_writedata[pm_status_pkg::counter_clear_bit];
   assign wrap       = osc_edge && state_reg.run && !clear_req && state_reg.count == 16'hffff;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      keep_next  = keep_reg;
      state_next.osc_prev = slow_oscillator;

      // Counter keeps going in every power mode; no sleep input gates it
      if (clear_req)
      begin
         state_next.count = pm_status_pkg::counter_reset;
      end
      else if (osc_edge && state_reg.run)
      begin
         state_next.count = 16'(state_reg.count + pm_status_pkg::counter_one);
      end

      // Set is applied after the clear so a present warning always wins
      if (ack_req && !below_warn)
      begin
         state_next.flag = 1'b0;
      end
      if (below_warn)
      begin
         state_next.flag = 1'b1;
      end

      if (accept_wr)
      begin
         case (index)
            pm_status_pkg::idx_page_control:
            begin
               state_next.page = avs_writedata[pm_status_pkg::counter_page_bit];
               if (state_reg.page)
               begin
                  state_next.run = avs_writedata[pm_status_pkg::counter_run_bit];
               end
            end
            pm_status_pkg::idx_warning_ctrl:
            begin
               keep_next.detect_sel = avs_writedata[pm_status_pkg::detect_level_bit];
               keep_next.warn_sel   = avs_writedata[pm_status_pkg::warning_level_bit];
            end
            pm_status_pkg::idx_irq_mask:
            begin
               state_next.irq_mask = avs_writedata[1:0];
            end
            default:
            begin
               state_next.irq_mask = state_reg.irq_mask;
            end
         endcase
      end

      // Interrupt status: write one to clear, a new event in the same cycle wins
      if (accept_wr && index == pm_status_pkg::idx_irq_status)
      begin
         state_next.irq_status = state_reg.irq_status & ~avs_writedata[1:0];
      end
      if (below_warn && !state_reg.flag)
      begin
         state_next.irq_status[pm_status_pkg::irq_warning_bit] = 1'b1;
      end
      if (wrap)
      begin
         state_next.irq_status[pm_status_pkg::irq_wrap_bit] = 1'b1;
      end
      state_next.irq = |(state_next.irq_status & state_next.irq_mask);

      // Bus: one wait cycle, read data captured on the cycle the request is seen
      state_next.waitreq = 1'b1;
      if ((avs_read || avs_write) && state_reg.waitreq)
      begin
         state_next.waitreq = 1'b0;
      end
      state_next.rdata = pm_status_pkg::byte_reset;
      if (avs_read && state_reg.waitreq)
      begin
         case (index)
            pm_status_pkg::idx_value_high:
            begin
               // Page zero hands the address back to a register outside this block
               if (state_reg.page)
               begin
                  state_next.rdata = state_reg.count[15:8];
               end
            end
            pm_status_pkg::idx_value_low:
            begin
               if (state_reg.page)
               begin
                  state_next.rdata = state_reg.count[7:0];
               end
            end
            pm_status_pkg::idx_page_control:
            begin
               state_next.rdata[pm_status_pkg::counter_run_bit] = state_reg.run;
            end
            pm_status_pkg::idx_warning_ctrl:
            begin
               state_next.rdata[pm_status_pkg::warning_flag_bit]  = state_reg.flag;
               state_next.rdata[pm_status_pkg::detect_level_bit]  = keep_reg.detect_sel;
               state_next.rdata[pm_status_pkg::warning_level_bit] = keep_reg.warn_sel;
            end
            pm_status_pkg::idx_irq_status:
            begin
               state_next.rdata[1:0] = state_reg.irq_status;
            end
            pm_status_pkg::idx_irq_mask:
            begin
               state_next.rdata[1:0] = state_reg.irq_mask;
            end
            default:
            begin
               state_next.rdata = pm_status_pkg::byte_reset;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg.count      <= pm_status_pkg::counter_reset;
         state_reg.run        <= 1'b0;
         state_reg.page       <= 1'b0;
         state_reg.osc_prev   <= 1'b0;
         state_reg.flag       <= 1'b0;
         state_reg.irq_status <= pm_status_pkg::irq_reset;
         state_reg.irq_mask   <= pm_status_pkg::irq_reset;
         state_reg.rdata      <= pm_status_pkg::byte_reset;
         state_reg.waitreq    <= 1'b1;
         state_reg.irq        <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Trip selects live in their own reset domain so ordinary resets leave them alone
   always_ff @(posedge clock or negedge power_on_resetn)
   begin
      if (!power_on_resetn)
      begin
         keep_reg <= '0;
      end
      else
      begin
         keep_reg <= keep_next;
      end
   end

   assign avs_readdata         = {24'h000000, state_reg.rdata};
   assign avs_waitrequest      = state_reg.waitreq;
   assign detect_level_select  = keep_reg.detect_sel;
   assign warning_level_select = keep_reg.warn_sel;
   assign irq                  = state_reg.irq;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic done_rd;
   assign done_rd = avs_read && !avs_waitrequest;

   a_flag_sets: assert property (@(posedge clock) disable iff (!resetn)
      below_warn |=> state_reg.flag)
      else $error("warning flag not set under low supply");

   a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
      state_reg.flag && !ack_req |=> state_reg.flag)
      else $error("warning flag dropped without acknowledge");

   a_ack_clears: assert property (@(posedge clock) disable iff (!resetn)
      ack_req && !below_warn |=> !state_reg.flag)
      else $error("acknowledge did not clear warning flag");

   a_detect_write: assert property (@(posedge clock) disable iff (!resetn || !power_on_resetn)
      accept_wr && index == pm_status_pkg::idx_warning_ctrl
      |=> detect_level_select == $past(avs_writedata[pm_status_pkg::detect_level_bit]))
      else $error("detect select not updated");

   a_warn_select: assert property (@(posedge clock) disable iff (!resetn || !power_on_resetn)
      (warning_level_select ? supply_below_high_trip : supply_below_low_trip) |=> state_reg.flag)
      else $error("warning select picked wrong trip");

   a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
      done_rd && index == pm_status_pkg::idx_warning_ctrl |-> avs_readdata[6] == 1'b0 && avs_readdata[3:0] == 4'h0)
      else $error("reserved warning bits not zero");

   a_count_step: assert property (@(posedge clock) disable iff (!resetn)
      osc_edge && state_reg.run && !clear_req |=> state_reg.count == $past(state_reg.count) + pm_status_pkg::counter_one)
      else $error("counter missed an oscillator edge");

   a_count_halt: assert property (@(posedge clock) disable iff (!resetn)
      !state_reg.run && !clear_req |=> $stable(state_reg.count))
      else $error("halted counter moved");

   a_count_clear: assert property (@(posedge clock) disable iff (!resetn)
      clear_req |=> state_reg.count == pm_status_pkg::counter_reset)
      else $error("clear did not zero the counter");

   a_high_byte: assert property (@(posedge clock) disable iff (!resetn)
      done_rd && index == pm_status_pkg::idx_value_high && $past(state_reg.page)
      |-> avs_readdata[7:0] == $past(state_reg.count[15:8]))
      else $error("high byte read wrong");

   a_page_out: assert property (@(posedge clock) disable iff (!resetn)
      done_rd && index == pm_status_pkg::idx_value_low && !$past(state_reg.page) |-> avs_readdata == 32'h0)
      else $error("paged-out address showed the count");

   a_ctrl_read: assert property (@(posedge clock) disable iff (!resetn)
      done_rd && index == pm_status_pkg::idx_page_control |-> avs_readdata[7:6] == 2'b00 && avs_readdata[4:0] == 5'h00)
      else $error("write-only control bits read non-zero");

   a_low_byte: assert property (@(posedge clock) disable iff (!resetn)
      done_rd && index == pm_status_pkg::idx_value_low && $past(state_reg.page)
      |-> avs_readdata[7:0] == $past(state_reg.count[7:0]))
      else $error("low byte read wrong");

   a_run_gated: assert property (@(posedge clock) disable iff (!resetn)
      accept_wr && index == pm_status_pkg::idx_page_control && !state_reg.page |=> $stable(state_reg.run))
      else $error("run bit changed while paged out");

   a_page_keeps: assert property (@(posedge clock) disable iff (!resetn)
      !state_reg.page && !(accept_wr && index == pm_status_pkg::idx_page_control) |=> $stable(state_reg.run))
      else $error("paged-out counter control changed");

   a_answer_next: assert property (@(posedge clock) disable iff (!resetn)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait cycle");

   a_wait_single: assert property (@(posedge clock) disable iff (!resetn)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
      irq == |(state_reg.irq_status & state_reg.irq_mask))
      else $error("interrupt output disagrees with status and mask");

   a_status_sticky: assert property (@(posedge clock) disable iff (!resetn)
      state_reg.irq_status[pm_status_pkg::irq_warning_bit]
      && !(accept_wr && index == pm_status_pkg::idx_irq_status && avs_writedata[pm_status_pkg::irq_warning_bit])
      |=> state_reg.irq_status[pm_status_pkg::irq_warning_bit])
      else $error("warning status dropped without a clear");

   // Trip selects must ride through an ordinary reset; only power-on may touch them
   a_select_kept: assert property (@(posedge clock) disable iff (!power_on_resetn)
      !resetn |=> $stable({detect_level_select, warning_level_select}))
      else $error("trip select changed during ordinary reset");

endmodule

// >>> verification/testbench.sv
// Purpose : Self-checking bench for the warning flag, trip selects and paged running counter
// Assumes : Bus requests wait for waitrequest low; slow_oscillator changes are spaced two clocks apart
// Notes   : Counter wrap needs 65536 steps and is left out to keep the run short
`timescale 1ns/10ps
module testbench;
   logic        clock;
   logic        resetn;
   logic        power_on_resetn;
   logic [15:0] avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        supply_below_low_trip;
   logic        supply_below_high_trip;
   logic        slow_oscillator;
   logic        detect_level_select;
   logic        warning_level_select;
   logic        irq;
   int          fail_count;
   int          samples_checked;
   int          cycles;

   pm_status_free_run_counter pm_status_free_run_counter_i
   (
      .clock                  (clock),
      .resetn                 (resetn),
      .power_on_resetn        (power_on_resetn),
      .avs_address            (avs_address),
      .avs_read               (avs_read),
      .avs_write              (avs_write),
      .avs_writedata          (avs_writedata),
      .avs_byteenable         (avs_byteenable),
      .avs_readdata           (avs_readdata),
      .avs_waitrequest        (avs_waitrequest),
      .supply_below_low_trip  (supply_below_low_trip),
      .supply_below_high_trip (supply_below_high_trip),
      .slow_oscillator        (slow_oscillator),
      .detect_level_select    (detect_level_select),
      .warning_level_select   (warning_level_select),
      .irq                    (irq)
   );

   // ------------------------------------------------------------
   // Clock, timeout and verdict
   // ------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Whole sequence needs about 870 cycles; the ceiling leaves wide margin
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count = fail_count + 1;
         $display("BAD %0t timeout", $time);
         close_out();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
      @(posedge clock);
      avs_address    <= {idx, 2'b00};
      avs_read       <= ~wr;
      avs_write      <= wr;
      avs_writedata  <= {24'h000000, d};
      avs_byteenable <= be;
      do
      begin
         @(posedge clock);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      chk({7'h00, |avs_readdata[31:8]}, 8'h00, "upper data");
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, 4'hf, q);
   endtask

   task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, 4'hf, q);
      chk(q, exp, "read");
   endtask

   task automatic rd_count(input logic [15:0] exp);
      rd(pm_status_pkg::idx_value_high, exp[15:8]);
      rd(pm_status_pkg::idx_value_low, exp[7:0]);
   endtask

   task automatic rst(input logic por);
      @(posedge clock);
      resetn <= 1'b0;
      if (por)
         power_on_resetn <= 1'b0;
      repeat (20) @(posedge clock);
      resetn          <= 1'b1;
      power_on_resetn <= 1'b1;
   endtask

   // Each change of the slow clock is one count step
   task automatic osc(input int n);
      repeat (n)
      begin
         @(posedge clock);
         slow_oscillator <= ~slow_oscillator;
         @(posedge clock);
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [7:0] q;
      fail_count = 0;
      samples_checked = 0;
      cycles = 0;
      resetn = 1'b0;
      power_on_resetn = 1'b0;
      avs_address = 16'h0000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      supply_below_low_trip = 1'b0;
      supply_below_high_trip = 1'b0;
      slow_oscillator = 1'b0;
      rst(1'b1);
      rd(pm_status_pkg::idx_warning_ctrl, 8'h00);
      rd(pm_status_pkg::idx_page_control, 8'h00);
      rd_count(16'h0000);
      rd(pm_status_pkg::idx_irq_status, 8'h00);
      rd(14'h1900, 8'h00);
      // Selects, reserved bits, ignored write without byte enable
      wr(pm_status_pkg::idx_warning_ctrl, 8'h3f);
      rd(pm_status_pkg::idx_warning_ctrl, 8'h30);
      chk({7'h00, detect_level_select}, 8'h01, "detect sel");
      chk({7'h00, warning_level_select}, 8'h01, "warning sel");
      bus(1'b1, pm_status_pkg::idx_warning_ctrl, 8'h00, 4'h0, q);
      rd(pm_status_pkg::idx_warning_ctrl, 8'h30);
      // Warning against the high trip, sticky, acknowledge, interrupt
      wr(pm_status_pkg::idx_irq_mask, 8'h01);
      supply_below_high_trip <= 1'b1;
      rd(pm_status_pkg::idx_warning_ctrl, 8'hb0);
      chk({7'h00, irq}, 8'h01, "irq set");
      wr(pm_status_pkg::idx_warning_ctrl, 8'h70);
      rd(pm_status_pkg::idx_warning_ctrl, 8'hb0);
      supply_below_high_trip <= 1'b0;
      rd(pm_status_pkg::idx_warning_ctrl, 8'hb0);
      wr(pm_status_pkg::idx_warning_ctrl, 8'h70);
      rd(pm_status_pkg::idx_warning_ctrl, 8'h30);
      rd(pm_status_pkg::idx_irq_status, 8'h01);
      wr(pm_status_pkg::idx_irq_status, 8'h01);
      rd(pm_status_pkg::idx_irq_status, 8'h00);
      chk({7'h00, irq}, 8'h00, "irq clear");
      // Low trip selected: only the low comparator counts
      wr(pm_status_pkg::idx_warning_ctrl, 8'h00);
      supply_below_high_trip <= 1'b1;
      rd(pm_status_pkg::idx_warning_ctrl, 8'h00);
      chk({7'h00, detect_level_select}, 8'h00, "detect low");
      supply_below_low_trip <= 1'b1;
      rd(pm_status_pkg::idx_warning_ctrl, 8'h80);
      supply_below_low_trip <= 1'b0;
      wr(pm_status_pkg::idx_warning_ctrl, 8'h30);
      rst(1'b0);
      rd(pm_status_pkg::idx_warning_ctrl, 8'hb0);
      rst(1'b1);
      rd(pm_status_pkg::idx_warning_ctrl, 8'h00);
      supply_below_high_trip <= 1'b0;
      // Counter: interrupts masked, page in, clear while halted, run, halt, page out
      wr(pm_status_pkg::idx_irq_mask, 8'h00);
      wr(pm_status_pkg::idx_page_control, 8'h21);
      wr(pm_status_pkg::idx_page_control, 8'h81);
      rd_count(16'h0000);
      rd(pm_status_pkg::idx_page_control, 8'h00);
      osc(5);
      rd_count(16'h0000);
      wr(pm_status_pkg::idx_page_control, 8'h21);
      rd(pm_status_pkg::idx_page_control, 8'h20);
      osc(300);
      rd_count(16'h012c);
      wr(pm_status_pkg::idx_page_control, 8'h01);
      osc(4);
      rd_count(16'h012c);
      wr(pm_status_pkg::idx_page_control, 8'h21);
      wr(pm_status_pkg::idx_page_control, 8'h20);
      rd_count(16'h0000);
      osc(6);
      wr(pm_status_pkg::idx_page_control, 8'h21);
      rd_count(16'h0132);
      wr(pm_status_pkg::idx_page_control, 8'ha1);
      rd_count(16'h0000);
      osc(1);
      wr(pm_status_pkg::idx_page_control, 8'h21);
      rd_count(16'h0001);
      wr(pm_status_pkg::idx_page_control, 8'h20);
      wr(pm_status_pkg::idx_irq_mask, 8'h01);
      rd(pm_status_pkg::idx_page_control, 8'h20);
      close_out();
   end
endmodule
